// ---- rtl/xport_pkg.sv ----
/*
 * shared constants and carriers for the expansion port engine
 * assumes a single 50 MHz system clock and pins sampled through synchronisers
 */
package xport_pkg;
    localparam int DATA_W = 32;
    // pins that pass the synchronisers: 6 control pins, 2 straps, data
    localparam int SYNC_W = 8 + DATA_W;
    // strobe phases in system clock cycles
    localparam logic [3:0] SETUP_CYC = 4'h2;
    localparam logic [3:0] STROBE_CYC = 4'h6;
    localparam logic [3:0] HOLD_CYC = 4'h3;
    // cycles after reset release before straps are taken (filter fill plus one)
    localparam logic [2:0] STRAP_CYC = 3'h4;
    // host port targets selected by the control input
    localparam logic TARGET_ADDR = 1'b0;
    localparam logic TARGET_DATA = 1'b1;
    // host mode strap value for asynchronous host mode
    localparam logic HOST_MODE_ASYNC = 1'b0;
    // reset values
    localparam logic [DATA_W-1:0] ADDR_RESET = 32'h0000_0000;
    localparam logic [DATA_W-1:0] DATA_RESET = 32'h0000_0000;

    typedef enum {M_IDLE, M_REQ, M_SETUP, M_STROBE, M_HOLD, M_DONE, M_REL} master_state_e;
    typedef enum {S_IDLE, S_WAIT, S_DONE} slave_state_e;

    // transfer that local logic asks the outbound port to perform
    typedef struct packed {
        logic write;
        logic target;
        logic [DATA_W-1:0] wdata;
    } master_req_s;

    // access that the far master makes into local memory
    typedef struct packed {
        logic write;
        logic [DATA_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } host_acc_s;
endpackage

// ---- rtl/xport_engine.sv ----
/*
 * expansion port engine of one processor: outbound asynchronous master,
 * inbound asynchronous host slave and hold/grant arbitration.
 * assumes external glue forms the slave select and buffers contended lines;
 * all pin inputs are asynchronous and pass four flip-flops: three synchroniser stages and a filter.
 */
// What this block does
// RULE1 - arbiter strap 1 takes hold request in, drives grant; 0 does the reverse
// RULE2 - non-arbiter asks with hold request; arbiter answers with grant, wired directly
// RULE3 - glue forms slave select from master space select, read and write strobes
// RULE4 - slave read/write select comes from master output enable, low means read
// RULE5 - slave stalls master with ready; master samples ready as input
// RULE6 - slave control input picks address register or data path
// RULE7 - data lines isolated during reset; switch closed afterwards by an output (none here; the far model switch follows rst_n)
// RULE8 - with more processors, add address decode into slave select
// RULE9 - port control outputs always driven; read/write select driven while master
// RULE10 - glue tri-states each output enable when not master nor transacting
// RULE11 - slave drives ready continuously; both may be slaves during hand-over
// RULE12 - glue disables both ready outputs while both processors are slaves
// RULE13 - each ready line has a pull-up for an inactive level
// RULE14 - buffer enables follow which processor is master, both off in hand-over
// RULE15 - buffer enables equal the given functions of space selects and grant
// RULE16 - host port strapped at reset for asynchronous host mode with bit 0
// RULE17 - glue logic is purely combinational with no clock or state
`timescale 1ns/100ps
module xport_engine
    import xport_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // reset straps
    input wire logic internal_arbiter_enable,
    input wire logic host_mode_strap,
    // arbitration pins
    input wire logic bus_hold_request_i,
    output logic bus_hold_request_o,
    output logic bus_hold_request_oe,
    input wire logic bus_hold_grant_i,
    output logic bus_hold_grant_o,
    output logic bus_hold_grant_oe,
    // outbound master pins
    output logic master_space0_select_n,
    output logic master_read_strobe_n,
    output logic master_write_strobe_n,
    output logic master_output_enable_n,
    output logic master_address_bit2,
    // inbound host pins
    input wire logic slave_chip_select_n,
    input wire logic slave_target_control,
    input wire logic slave_rw_select_i,
    output logic slave_rw_select_o,
    output logic slave_rw_select_oe,
    input wire logic slave_ready_i,
    output logic slave_ready_o,
    output logic slave_ready_oe,
    // shared data lines
    input wire logic [DATA_W-1:0] shared_data_lines_i,
    output logic [DATA_W-1:0] shared_data_lines_o,
    output logic shared_data_lines_oe,
    // local request to the outbound master
    input wire logic req_valid,
    input wire master_req_s req,
    output logic req_ready,
    output logic resp_valid,
    output logic [DATA_W-1:0] resp_rdata,
    // local memory access from the inbound host
    output logic acc_valid,
    output host_acc_s acc,
    input wire logic acc_ready,
    input wire logic [DATA_W-1:0] acc_rdata,
    // status
    output logic bus_owner
);
    logic [SYNC_W-1:0] pin_raw, s1_r, s2_r, s3_r, filt_r;
    logic hold_req_f, grant_f, cs_n_f, cntl_f, rw_f, ready_f, arb_pin_f, host_mode_strap_pin_f;
    logic [DATA_W-1:0] data_f;
    logic [2:0] strap_cnt_r, strap_cnt_nxt;
    logic cfg_ok_r, cfg_ok_nxt, arb_r, arb_nxt, host_async_r, host_async_nxt;
    logic owns;

    assign pin_raw = {bus_hold_request_i, bus_hold_grant_i, slave_chip_select_n, slave_target_control,
                      slave_rw_select_i, slave_ready_i, internal_arbiter_enable, host_mode_strap,
                      shared_data_lines_i};

    // three-stage synchroniser per pin; value changes once stages two and three agree
    genvar gi;
    generate
        for (gi = 0; gi < SYNC_W; gi = gi + 1)
        begin : g_sync
            always_ff @(posedge clk_sys or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    s1_r[gi] <= 1'b0;
                    s2_r[gi] <= 1'b0;
                    s3_r[gi] <= 1'b0;
                    filt_r[gi] <= 1'b0;
                end
                else
                begin
                    s1_r[gi] <= pin_raw[gi];
                    s2_r[gi] <= s1_r[gi];
                    s3_r[gi] <= s2_r[gi];
                    if (s2_r[gi] == s3_r[gi])
                        filt_r[gi] <= s3_r[gi];
                end
            end
        end
    endgenerate

    assign {hold_req_f, grant_f, cs_n_f, cntl_f, rw_f, ready_f, arb_pin_f, host_mode_strap_pin_f, data_f} = filt_r;

    // strap capture once the synchronisers have filled after reset
    always_comb
    begin
        strap_cnt_nxt = strap_cnt_r;
        cfg_ok_nxt = cfg_ok_r;
        arb_nxt = arb_r;
        host_async_nxt = host_async_r;
        if (!cfg_ok_r)
        begin
            if (strap_cnt_r == STRAP_CYC)
            begin
                cfg_ok_nxt = 1'b1;
                arb_nxt = arb_pin_f; // [RULE1]
                host_async_nxt = (host_mode_strap_pin_f == HOST_MODE_ASYNC); // [RULE16]
            end
            else
                strap_cnt_nxt = strap_cnt_r + 3'h1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            strap_cnt_r <= 3'h0;
            cfg_ok_r <= 1'b0;
            arb_r <= 1'b0;
            host_async_r <= 1'b0;
        end
        else
        begin
            strap_cnt_r <= strap_cnt_nxt;
            cfg_ok_r <= cfg_ok_nxt;
            arb_r <= arb_nxt;
            host_async_r <= host_async_nxt;
        end
    end

    // ---- outbound master and arbitration ----
    master_state_e mst_r, mst_nxt;
    master_req_s cur_r, cur_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic grant_r, grant_nxt, hreq_r, hreq_nxt;
    logic sel_n_r, sel_n_nxt, re_n_r, re_n_nxt, we_n_r, we_n_nxt, oe_n_r, oe_n_nxt;
    logic mdrive_r, mdrive_nxt, done_r, done_nxt;
    logic [DATA_W-1:0] rdata_r, rdata_nxt;

    // arbiter grants only while its own master is idle; owner flag follows grant
    assign owns = cfg_ok_r & (arb_r ? ~grant_r : grant_f);

    always_comb
    begin
        mst_nxt = mst_r;
        cur_nxt = cur_r;
        cnt_nxt = cnt_r;
        grant_nxt = grant_r;
        hreq_nxt = hreq_r;
        sel_n_nxt = sel_n_r;
        re_n_nxt = re_n_r;
        we_n_nxt = we_n_r;
        oe_n_nxt = oe_n_r;
        mdrive_nxt = mdrive_r;
        done_nxt = 1'b0;
        rdata_nxt = rdata_r;
        // arbiter side: answer hold request with grant while idle and no local request waits, drop it when request drops
        if (cfg_ok_r && arb_r)
        begin
            if (!hold_req_f)
                grant_nxt = 1'b0;
            else if (mst_r == M_IDLE && !(req_valid && !grant_r))
                grant_nxt = 1'b1; // [RULE2]
        end
        case (mst_r)
            M_IDLE:
            begin
                if (cfg_ok_r && req_valid)
                begin
                    cur_nxt = req;
                    if (arb_r)
                    begin
                        if (!grant_r && !hold_req_f)
                            mst_nxt = M_SETUP;
                    end
                    else
                    begin
                        hreq_nxt = 1'b1; // [RULE2]
                        mst_nxt = M_REQ;
                    end
                end
            end
            M_REQ:
            begin
                if (grant_f) // [RULE1]
                    mst_nxt = M_SETUP;
            end
            M_SETUP:
            begin
                sel_n_nxt = 1'b0;
                oe_n_nxt = cur_r.write; // low output enable marks a read
                mdrive_nxt = cur_r.write;
                if (cnt_r == SETUP_CYC - 4'h1)
                begin
                    cnt_nxt = 4'h0;
                    re_n_nxt = cur_r.write;
                    we_n_nxt = ~cur_r.write;
                    mst_nxt = M_STROBE;
                end
                else
                    cnt_nxt = cnt_r + 4'h1;
            end
            M_STROBE:
            begin
                if (cnt_r < STROBE_CYC - 4'h1)
                    cnt_nxt = cnt_r + 4'h1;
                else if (ready_f) // stall until far slave is ready [RULE5]
                begin
                    cnt_nxt = 4'h0;
                    re_n_nxt = 1'b1;
                    we_n_nxt = 1'b1;
                    rdata_nxt = cur_r.write ? rdata_r : data_f;
                    mst_nxt = M_HOLD;
                end
            end
            M_HOLD:
            begin
                if (cnt_r == HOLD_CYC - 4'h1)
                begin
                    cnt_nxt = 4'h0;
                    sel_n_nxt = 1'b1;
                    oe_n_nxt = 1'b1;
                    mdrive_nxt = 1'b0;
                    mst_nxt = M_DONE;
                end
                else
                    cnt_nxt = cnt_r + 4'h1;
            end
            M_DONE:
            begin
                done_nxt = 1'b1;
                hreq_nxt = 1'b0;
                mst_nxt = arb_r ? M_IDLE : M_REL;
            end
            M_REL:
            begin
                if (!grant_f)
                    mst_nxt = M_IDLE;
            end
            default:
                mst_nxt = M_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mst_r <= M_IDLE;
            cur_r <= '0;
            cnt_r <= 4'h0;
            grant_r <= 1'b0;
            hreq_r <= 1'b0;
            sel_n_r <= 1'b1;
            re_n_r <= 1'b1;
            we_n_r <= 1'b1;
            oe_n_r <= 1'b1;
            mdrive_r <= 1'b0;
            done_r <= 1'b0;
            rdata_r <= DATA_RESET;
        end
        else
        begin
            mst_r <= mst_nxt;
            cur_r <= cur_nxt;
            cnt_r <= cnt_nxt;
            grant_r <= grant_nxt;
            hreq_r <= hreq_nxt;
            sel_n_r <= sel_n_nxt;
            re_n_r <= re_n_nxt;
            we_n_r <= we_n_nxt;
            oe_n_r <= oe_n_nxt;
            mdrive_r <= mdrive_nxt;
            done_r <= done_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // ---- inbound asynchronous host slave ----
    slave_state_e slv_r, slv_nxt;
    logic cs_q_r, cs_q_nxt, rdy_r, rdy_nxt, sdrive_r, sdrive_nxt, acc_v_r, acc_v_nxt;
    logic [DATA_W-1:0] haddr_r, haddr_nxt, sdata_r, sdata_nxt;
    host_acc_s acc_r, acc_nxt;

    always_comb
    begin
        slv_nxt = slv_r;
        cs_q_nxt = cs_n_f;
        rdy_nxt = rdy_r;
        sdrive_nxt = sdrive_r;
        acc_v_nxt = acc_v_r;
        haddr_nxt = haddr_r;
        sdata_nxt = sdata_r;
        acc_nxt = acc_r;
        case (slv_r)
            S_IDLE:
            begin
                if (!owns && host_async_r && cs_q_r && !cs_n_f) // select fell
                begin
                    if (cntl_f == TARGET_ADDR) // [RULE6]
                    begin
                        if (rw_f)
                            haddr_nxt = data_f;
                        sdata_nxt = haddr_r;
                        slv_nxt = S_DONE;
                    end
                    else
                    begin
                        rdy_nxt = 1'b0; // hold master off [RULE5]
                        acc_v_nxt = 1'b1;
                        acc_nxt.write = rw_f;
                        acc_nxt.addr = haddr_r;
                        acc_nxt.wdata = data_f;
                        slv_nxt = S_WAIT;
                    end
                end
            end
            S_WAIT:
            begin
                if (acc_ready)
                begin
                    acc_v_nxt = 1'b0;
                    sdata_nxt = acc_rdata;
                    haddr_nxt = haddr_r + 32'h0000_0004;
                    slv_nxt = S_DONE;
                end
            end
            S_DONE:
            begin
                rdy_nxt = 1'b1;
                sdrive_nxt = ~rw_f & ~cs_n_f; // low read/write select marks a read
                if (cs_n_f)
                    slv_nxt = S_IDLE;
            end
            default:
                slv_nxt = S_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            slv_r <= S_IDLE;
            cs_q_r <= 1'b1;
            rdy_r <= 1'b1;
            sdrive_r <= 1'b0;
            acc_v_r <= 1'b0;
            haddr_r <= ADDR_RESET;
            sdata_r <= DATA_RESET;
            acc_r <= '0;
        end
        else
        begin
            slv_r <= slv_nxt;
            cs_q_r <= cs_q_nxt;
            rdy_r <= rdy_nxt;
            sdrive_r <= sdrive_nxt;
            acc_v_r <= acc_v_nxt;
            haddr_r <= haddr_nxt;
            sdata_r <= sdata_nxt;
            acc_r <= acc_nxt;
        end
    end

    // pin drivers: port controls always driven, role pins by strap
    assign bus_hold_request_o = hreq_r;
    assign bus_hold_request_oe = cfg_ok_r & ~arb_r; // [RULE1]
    assign bus_hold_grant_o = grant_r;
    assign bus_hold_grant_oe = cfg_ok_r & arb_r; // [RULE1]
    assign master_space0_select_n = sel_n_r; // [RULE9]
    assign master_read_strobe_n = re_n_r;
    assign master_write_strobe_n = we_n_r;
    assign master_output_enable_n = oe_n_r; // [RULE9]
    assign master_address_bit2 = cur_r.target;
    assign slave_rw_select_o = oe_n_r;
    assign slave_rw_select_oe = owns; // [RULE9]
    assign slave_ready_o = rdy_r;
    assign slave_ready_oe = cfg_ok_r & ~owns; // [RULE11]
    assign shared_data_lines_o = mdrive_r ? cur_r.wdata : sdata_r;
    assign shared_data_lines_oe = mdrive_r | sdrive_r;
    assign req_ready = (mst_r == M_IDLE) & cfg_ok_r & (arb_r ? (~grant_r & ~hold_req_f) : 1'b1);
    assign resp_valid = done_r;
    assign resp_rdata = rdata_r;
    assign acc_valid = acc_v_r;
    assign acc = acc_r;
    assign bus_owner = owns;
endmodule

// ---- verif/xport_engine_asserts.sv ----
/* pin checker for the expansion port engine
   assumes straps change only while rst_n is low */
`timescale 1ns/100ps
module xport_engine_asserts (
    // clock, reset and straps
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic internal_arbiter_enable,
    input wire logic host_mode_strap,
    // arbitration
    input wire logic bus_hold_request_i,
    input wire logic bus_hold_request_oe,
    input wire logic bus_hold_grant_o,
    input wire logic bus_hold_grant_oe,
    input wire logic bus_owner,
    // outbound master
    input wire logic master_space0_select_n,
    input wire logic master_read_strobe_n,
    input wire logic master_write_strobe_n,
    input wire logic master_output_enable_n,
    // inbound host
    input wire logic slave_rw_select_o,
    input wire logic slave_rw_select_oe,
    input wire logic slave_ready_o,
    input wire logic slave_ready_oe,
    input wire logic acc_valid
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // hold pin directions follow the strap
    role_pins_a: assert property ((bus_hold_grant_oe || bus_hold_request_oe) |->
        bus_hold_grant_oe == internal_arbiter_enable && bus_hold_request_oe != internal_arbiter_enable)
        else $error("hold pin roles wrong");
    // grant only answers a standing request, and drops once it is gone
    grant_cause_a: assert property (bus_hold_grant_oe && $rose(bus_hold_grant_o) |->
        $past(bus_hold_request_i, 2)) else $error("grant without request");
    grant_drop_a: assert property (!bus_hold_request_i [*8] |->
        !(bus_hold_grant_oe && bus_hold_grant_o)) else $error("grant held without request");
    // strobes sit inside the space select and keep their width
    strobe_select_a: assert property ((!master_read_strobe_n || !master_write_strobe_n) |->
        !master_space0_select_n) else $error("strobe outside select");
    strobe_len_a: assert property ($fell(master_write_strobe_n) || $fell(master_read_strobe_n) |->
        (!master_write_strobe_n || !master_read_strobe_n) [*6]) else $error("strobe too short");
    // output enable marks reads, and the host direction pin copies it while owner
    oe_dir_a: assert property (master_read_strobe_n != master_write_strobe_n |->
        master_output_enable_n == master_read_strobe_n) else $error("output enable wrong");
    rw_pin_a: assert property (master_read_strobe_n != master_write_strobe_n |->
        slave_rw_select_oe && slave_rw_select_o == master_read_strobe_n) else $error("direction pin wrong");
    // ready low while the local memory has not answered; driven only as slave
    ready_stall_a: assert property (acc_valid |-> !slave_ready_o) else $error("ready high in access");
    ready_drive_a: assert property (slave_ready_oe |->
        !bus_owner && master_space0_select_n) else $error("ready driven as owner");
    host_off_a: assert property (host_mode_strap |-> !acc_valid && slave_ready_o)
        else $error("access taken in other host mode");
    // main scenarios reached
    grant_c: cover property ($rose(bus_hold_grant_o));
    write_c: cover property ($fell(master_write_strobe_n));
    access_c: cover property ($rose(acc_valid));
endmodule
bind xport_engine xport_engine_asserts i_xport_engine_asserts (.*);

// ---- verif/far_xport_model.sv ----
/* far processor with its glue: slave behind our outbound master, arbiter or requester
   assumes the bench resolves the shared data lines */
`timescale 1ns/100ps
module far_xport_model
    import xport_pkg::*;
(
    // clock, reset and bench commands
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic internal_arbiter_enable,
    input wire logic far_want,
    input wire logic [3:0] stall,
    input wire logic [DATA_W-1:0] rd_word,
    // pins of our engine
    input wire logic master_space0_select_n,
    input wire logic master_read_strobe_n,
    input wire logic master_write_strobe_n,
    input wire logic master_output_enable_n,
    input wire logic bus_hold_request_o,
    input wire logic bus_hold_request_oe,
    input wire logic bus_hold_grant_o,
    input wire logic [DATA_W-1:0] shared_data_lines_o,
    // lines the far side drives
    output logic bus_hold_request_i,
    output logic bus_hold_grant_i,
    output logic slave_ready_i,
    output logic [DATA_W-1:0] far_d,
    output logic far_d_oe,
    output logic [DATA_W-1:0] last_w
);
    logic sel_n;
    logic near_buf_n;
    logic [3:0] wait_cnt;
    logic [1:0] grant_dly;
    // glue: select held off until a strobe falls; two ends only, no address decode
    assign sel_n = master_space0_select_n | (master_read_strobe_n & master_write_strobe_n);
    // buffer toward our end on while we master: select low, grant in our favour
    assign near_buf_n = master_space0_select_n | (internal_arbiter_enable ? bus_hold_grant_o : !bus_hold_grant_i);
    // ready pulled up while the far slave is not selected or its buffer is off
    assign slave_ready_i = near_buf_n | sel_n | (wait_cnt >= stall);
    // output enable low means read, so the far slave drives data; switch open in reset
    assign far_d_oe = rst_n && !sel_n && !master_output_enable_n;
    assign far_d = rd_word;
    // far end takes the opposite arbitration role
    assign bus_hold_request_i = internal_arbiter_enable && far_want;
    assign bus_hold_grant_i = grant_dly[1];
    // grant delay, ready stall count, write capture
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            grant_dly <= 2'h0;
            wait_cnt <= 4'h0;
            last_w <= 32'h0;
        end
        else
        begin
            grant_dly <= {grant_dly[0], bus_hold_request_o & bus_hold_request_oe};
            wait_cnt <= sel_n ? 4'h0 : wait_cnt + {3'h0, wait_cnt != 4'hf};
            if (!sel_n && !master_write_strobe_n)
                last_w <= shared_data_lines_o;
        end
    end
endmodule

// ---- verif/xport_engine_bench.sv ----
/* self-checking bench for the expansion port engine
   assumes the far model and the pin checker are compiled before it */
`timescale 1ns/100ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
    $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module xport_engine_bench
    import xport_pkg::*;
;
    logic clk_sys = 1'b0;
    logic idle_bit = 1'b0;
    logic rst_n, internal_arbiter_enable, host_mode_strap, far_want, tb_rw, tb_d_oe;
    logic bus_hold_request_i, bus_hold_request_o, bus_hold_request_oe;
    logic bus_hold_grant_i, bus_hold_grant_o, bus_hold_grant_oe, bus_owner;
    logic master_space0_select_n, master_read_strobe_n, master_write_strobe_n;
    logic master_output_enable_n, master_address_bit2, slave_chip_select_n, slave_target_control;
    logic slave_rw_select_i, slave_rw_select_o, slave_rw_select_oe;
    logic slave_ready_i, slave_ready_o, slave_ready_oe, shared_data_lines_oe, far_d_oe;
    logic [DATA_W-1:0] shared_data_lines_i, shared_data_lines_o, far_d, tb_d, rd_word, last_w;
    logic [DATA_W-1:0] resp_rdata, acc_rdata;
    logic [3:0] stall;
    logic req_valid, req_ready, resp_valid, acc_valid, acc_ready;
    master_req_s req;
    host_acc_s acc;
    int fail_count = 0;
    int total_checks = 0;
    // clock and an idle pattern that toggles on undriven data
    always #10 clk_sys = ~clk_sys;
    always @(posedge clk_sys) idle_bit <= ~idle_bit;
    // resolve the shared lines
    assign shared_data_lines_i = shared_data_lines_oe ? shared_data_lines_o : far_d_oe ? far_d :
        tb_d_oe ? tb_d : {DATA_W{idle_bit}};
    assign slave_rw_select_i = slave_rw_select_oe ? slave_rw_select_o : tb_rw;
    xport_engine i_xport_engine (.*);
    far_xport_model i_far_xport_model (.*);
    task automatic tick(int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // wait at least one edge for a level, bounded
    task automatic wait_for(ref logic s, input logic v, input string nm);
        int n = 0;
        do
        begin
            tick(1);
            n++;
        end
        while (s !== v && n < 200);
        `CHK(nm, v, s)
    endtask
    task automatic do_reset(logic arb, logic host);
        rst_n <= 1'b0;
        internal_arbiter_enable <= arb;
        host_mode_strap <= host;
        tick(12);
        `CHK("reset strobes", 3'h7, {master_space0_select_n, master_read_strobe_n, master_write_strobe_n})
        `CHK("reset enables", 3'h0, {bus_hold_request_oe, bus_hold_grant_oe, shared_data_lines_oe})
        rst_n <= 1'b1;
        tick(6);
        `CHK("hold roles", {arb, !arb}, {bus_hold_grant_oe, bus_hold_request_oe})
    endtask
    // one local transfer: hand over, wait for the end pulse
    task automatic local_xfer(logic w, logic [DATA_W-1:0] d);
        req <= '{write: w, target: w, wdata: d};
        req_valid <= 1'b1;
        wait_for(req_ready, 1'b1, "request taken");
        req_valid <= 1'b0;
        wait_for(resp_valid, 1'b1, "transfer end");
        `CHK("owner at end", 1'b1, bus_owner)
        `CHK("target bit", w, master_address_bit2)
        if (w)
            `CHK("written word", d, last_w)
        else
            `CHK("read word", rd_word, resp_rdata)
        tick(1);
        `CHK("end pulse", 1'b0, resp_valid)
    endtask
    // far master cycle into our host port
    task automatic host_cycle(logic tgt, logic wr, logic [DATA_W-1:0] d);
        slave_target_control <= tgt;
        tb_rw <= wr;
        tb_d <= d;
        tb_d_oe <= wr;
        tick(2);
        slave_chip_select_n <= 1'b0;
    endtask
    task automatic host_end();
        slave_chip_select_n <= 1'b1;
        tick(1);
        tb_d_oe <= 1'b0;
        tick(6);
    endtask
    task automatic t_outbound();
        do_reset(1'b0, 1'b0);
        rd_word <= 32'hc3a5_0f96;
        stall <= 4'h2;
        local_xfer(1'b1, 32'h1234_5678);
        stall <= 4'h9;
        local_xfer(1'b0, 32'h0);
        local_xfer(1'b1, 32'hfedc_ba98);
        wait_for(bus_owner, 1'b0, "bus handed back");
        $display("outbound test ended");
    endtask
    task automatic t_grant();
        do_reset(1'b1, 1'b0);
        far_want <= 1'b1;
        wait_for(bus_hold_grant_o, 1'b1, "grant raised");
        `CHK("owner while granted", 1'b0, bus_owner)
        req <= '{write: 1'b1, target: 1'b0, wdata: 32'h0f0f_7777};
        req_valid <= 1'b1;
        tick(3);
        `CHK("refused while granted", 1'b0, req_ready)
        req_valid <= 1'b0;
        far_want <= 1'b0;
        wait_for(bus_hold_grant_o, 1'b0, "grant dropped");
        local_xfer(1'b1, 32'h0f0f_7777);
        $display("grant test ended");
    endtask
    task automatic t_inbound();
        do_reset(1'b1, 1'b0);
        far_want <= 1'b1;
        wait_for(bus_hold_grant_o, 1'b1, "far master granted");
        host_cycle(TARGET_ADDR, 1'b1, 32'h0000_0100);
        tick(10);
        `CHK("address cycle ready", 2'h3, {slave_ready_o, slave_ready_oe})
        host_end();
        host_cycle(TARGET_DATA, 1'b0, 32'h0);
        wait_for(acc_valid, 1'b1, "read access");
        `CHK("read access", {1'b0, 32'h0000_0100}, {acc.write, acc.addr})
        tick(4);
        `CHK("ready held low", 1'b0, slave_ready_o)
        acc_rdata <= 32'h5a5a_e1e1;
        acc_ready <= 1'b1;
        tick(1);
        acc_ready <= 1'b0;
        wait_for(slave_ready_o, 1'b1, "ready back");
        `CHK("read data", {1'b1, 32'h5a5a_e1e1}, {shared_data_lines_oe, shared_data_lines_o})
        host_end();
        host_cycle(TARGET_DATA, 1'b1, 32'h0bad_f00d);
        wait_for(acc_valid, 1'b1, "write access");
        `CHK("write access", {1'b1, 32'h0000_0104, 32'h0bad_f00d}, acc)
        acc_ready <= 1'b1;
        tick(1);
        acc_ready <= 1'b0;
        host_end();
        $display("inbound test ended");
    endtask
    task automatic t_host_off();
        do_reset(1'b1, 1'b1);
        wait_for(bus_hold_grant_o, 1'b1, "far granted again");
        host_cycle(TARGET_DATA, 1'b0, 32'h0);
        tick(12);
        `CHK("ignored access", 2'h1, {acc_valid, slave_ready_o})
        host_end();
        $display("host mode test ended");
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // inputs at time zero, then the tests
    initial
    begin
        {rst_n, internal_arbiter_enable, host_mode_strap, far_want, tb_rw, tb_d_oe} = 6'h0;
        {slave_chip_select_n, slave_target_control, req_valid, acc_ready} = 4'h8;
        {tb_d, rd_word, acc_rdata, stall} = '0;
        req = '0;
        t_outbound();
        t_grant();
        t_inbound();
        t_host_off();
        close_out();
    end
    // watchdog far beyond the few hundred cycles the tests take
    initial
    begin
        tick(20000);
        fail_count++;
        close_out();
    end
endmodule
